//--- flash_seq_map.vh
// Constants for the flash row erase/write sequencer.
// Assumes a 32-bit APB slave at 10 MHz and an external flash array model.
// Function
// - Start with erase and enable set, config clear, erases whole addressed row
// - Erase or program begins only after keys 55h then AAh
// - Two instruction cycles of setup follow the go bit
// - Row erase stalls the CPU about 2 ms; clocks keep running
// - After erase the CPU resumes at third instruction after go
// - Programming never erases first
// - One program writes at most as many words as latches
// - Upper ten address bits pick row, low five bits pick latch
// - Programming stays inside the selected row
// - Every program or erase completion resets latches to 3FFF
// - Latch-only set: unlocked go only loads the addressed latch
// - Latch-only clear: load final latch, program all latches together
// - Interrupted key sequence loads nothing and starts nothing
// - Unloaded latches keep the blank value
// - Erase is offered only at row granularity
// - Go bits settable only; hardware clears them on completion
// - Reset during an operation sets the interrupted-program flag
// - Unlock key port is write-only and reads zero
// - Program enable clear at reset; program only while set
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH
// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define OFS_ADDR_LOW      12'h000
`define OFS_ADDR_HIGH     12'h004
`define OFS_DATA_LOW      12'h008
`define OFS_DATA_HIGH     12'h00C
`define OFS_CONTROL       12'h010
`define OFS_UNLOCK        12'h014
// ***********************************************************************
// Control register fields
// ***********************************************************************
`define CTL_FETCH_GO      0
`define CTL_PROG_GO       1
`define CTL_PROG_EN       2
`define CTL_WR_ERR        3
`define CTL_ERASE_SEL     4
`define CTL_LATCH_ONLY    5
`define CTL_CFG_SEL       6
// ***********************************************************************
// Values and timing
// ***********************************************************************
`define KEY_FIRST         8'h55
`define KEY_SECOND        8'hAA
`define BLANK_WORD        14'h3FFF
`define CLK_HZ            10000000
`define ERASE_TIME_US     2000
`define PROG_TIME_US      2000
`define SETUP_CYCLES      2
`endif

//--- unlock_tracker.v
// Unlock key tracker: arms on 55h then AAh written to the key port.
// Assumes one-cycle write strobes from the register slave.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module unlock_tracker (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Bus write events
   input  wire       any_wr,
   input  wire       key_wr,
   input  wire [7:0] key_data,
   input  wire       go_wr,
   // Armed state
   output wire       armed
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ONE  = 2'h1;
   localparam ST_TWO  = 2'h2;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   // Every bus write is an event here: a wrong key or a go breaks the pair too
   wire      wr_seen = any_wr || key_wr || go_wr;
   wire      key_one = key_wr && key_data == `KEY_FIRST;
   wire      key_two = key_wr && key_data == `KEY_SECOND;
   assign armed = (state_ff == ST_TWO);
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (key_one) begin
               nxt_state = ST_ONE;
            end
         end
         ST_ONE: begin
            if (key_two) begin
               nxt_state = ST_TWO;
            end else if (!key_one && wr_seen) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_TWO: begin
            // Go write consumes the unlock; a fresh first key restarts it
            if (key_one) begin
               nxt_state = ST_ONE;
            end else if (wr_seen) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end
   always @(posedge clk) begin
      if (rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
endmodule
`default_nettype wire

//--- write_latches.v
// Bank of 14-bit write latches, blank after reset and after each erase or program.
// Assumes the sequencer gives one-cycle load and blank strobes.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module write_latches #(
   parameter NUM = 32,
   parameter IW  = 5
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst,
   // Control
   input  wire             load,
   input  wire [IW-1:0]    idx,
   input  wire [13:0]      wdata,
   input  wire             blank,
   // Readout
   input  wire [IW-1:0]    rd_idx,
   output wire [13:0]      rd_data
);
   reg [13:0] latch_ff [0:NUM-1];
   integer i;
   assign rd_data = latch_ff[rd_idx];
   always @(posedge clk) begin
      for (i = 0; i < NUM; i = i + 1) begin
         if (rst || blank) begin
            latch_ff[i] <= `BLANK_WORD;
         end else if (load && idx == i[IW-1:0]) begin
            latch_ff[i] <= wdata;
         end
      end
   end
endmodule
`default_nettype wire

//--- flash_seq.v
// Flash row erase/write sequencer with APB register slave.
// Assumes an external flash array taking row erase and word programs.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_seq #(
   parameter NUM_LATCH = 32,
   parameter LW        = 5,
   parameter ERASE_CYC = (`ERASE_TIME_US * (`CLK_HZ / 1000000)),
   parameter PROG_CYC  = (`PROG_TIME_US * (`CLK_HZ / 1000000))
) (
   // Clock and reset
   input  wire        CLOCK,
   input  wire        RST,
   // APB slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // CPU stall
   output reg         CPU_STALL,
   // Flash array
   output reg         FL_ERASE,
   output reg         FL_PROG,
   output reg  [14:0] FL_ADDR,
   output reg  [13:0] FL_WDATA
);
   // ***********************************************************************
   // Sequencer states
   // ***********************************************************************
   localparam S_IDLE  = 3'h0;
   localparam S_SETUP = 3'h1;
   localparam S_ERASE = 3'h2;
   localparam S_PROG  = 3'h3;
   localparam S_DONE  = 3'h4;
   localparam integer SETUP_I = `SETUP_CYCLES;
   localparam [1:0]   SETUP_N = SETUP_I[1:0];
   function [23:0] min1;
      input [31:0] v;
      begin
         min1 = (v < 32'h1) ? 24'h1 : v[23:0];
      end
   endfunction
   localparam [23:0] ERASE_N = min1(ERASE_CYC);
   localparam [23:0] PROG_N  = min1(PROG_CYC);
   // ***********************************************************************
   // Registers
   // ***********************************************************************
   reg [7:0]  addr_lo_ff;
   reg [6:0]  addr_hi_ff;
   reg [7:0]  data_lo_ff;
   reg [5:0]  data_hi_ff;
   reg        prog_en_ff;
   reg        erase_sel_ff;
   reg        latch_only_ff;
   reg        cfg_sel_ff;
   reg        prog_go_ff;
   reg        fetch_go_ff;
   // Reset keeps the error flag, so it needs a power-up value of its own
   reg        wr_err_ff = 1'b0;
   reg        busy_ff   = 1'b0;
   reg [2:0]  state_ff;
   reg [2:0]  nxt_state;
   reg [23:0] cnt_ff;
   reg [23:0] nxt_cnt;
   reg [LW:0] widx_ff;
   reg        op_erase_ff;
   reg [9:0]  row_ff;
   wire       setup  = PSEL && !PENABLE;
   wire       access = PSEL && PENABLE;
   wire       wr_stb = access && PWRITE && PREADY;
   wire       key_wr = wr_stb && PADDR == `OFS_UNLOCK;
   wire       ctl_wr = wr_stb && PADDR == `OFS_CONTROL;
   wire       go_req = ctl_wr && PWDATA[`CTL_PROG_GO] && !prog_go_ff;
   wire       armed;
   wire [13:0] lat_rd;
   wire [LW-1:0] lat_idx = addr_lo_ff[LW-1:0];
   wire       go_ok = go_req && armed && prog_en_ff && !cfg_sel_ff;
   reg        lat_load;
   reg        lat_blank;
   // ***********************************************************************
   // Submodules
   // ***********************************************************************
   unlock_tracker u_unlock (
      .clk      (CLOCK),
      .rst      (RST),
      .any_wr   (wr_stb && !key_wr && !go_req),
      .key_wr   (key_wr),
      .key_data (PWDATA[7:0]),
      .go_wr    (go_req),
      .armed    (armed)
   );
   write_latches #(.NUM(NUM_LATCH), .IW(LW)) u_latch (
      .clk     (CLOCK),
      .rst     (RST),
      .load    (lat_load),
      .idx     (lat_idx),
      .wdata   ({data_hi_ff, data_lo_ff}),
      .blank   (lat_blank),
      .rd_idx  (widx_ff[LW-1:0]),
      .rd_data (lat_rd)
   );
   // ***********************************************************************
   // Sequencer
   // ***********************************************************************
   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      lat_load  = 1'b0;
      lat_blank = 1'b0;
      case (state_ff)
         S_IDLE: begin
            if (go_ok) begin
               nxt_state = S_SETUP;
               nxt_cnt   = 24'h1;
               // Last or only latch loaded with the go, in either mode
               lat_load  = !erase_sel_ff;
            end
         end
         S_SETUP: begin
            if (cnt_ff >= {22'h0, SETUP_N}) begin
               nxt_cnt = 24'h1;
               if (op_erase_ff) begin
                  nxt_state = S_ERASE;
               end else if (latch_only_ff) begin
                  nxt_state = S_IDLE;
               end else begin
                  nxt_state = S_PROG;
               end
            end else begin
               nxt_cnt = cnt_ff + 24'h1;
            end
         end
         S_ERASE: begin
            if (cnt_ff >= ERASE_N) begin
               nxt_state = S_DONE;
            end else begin
               nxt_cnt = cnt_ff + 24'h1;
            end
         end
         S_PROG: begin
            // One word per latch first, then the program time runs
            if (widx_ff == NUM_LATCH[LW:0] && cnt_ff >= PROG_N) begin
               nxt_state = S_DONE;
            end else begin
               nxt_cnt = (widx_ff == NUM_LATCH[LW:0]) ? cnt_ff + 24'h1 : cnt_ff;
            end
         end
         S_DONE: begin
            lat_blank = 1'b1;
            nxt_state = S_IDLE;
         end
         default: nxt_state = S_IDLE;
      endcase
   end
   always @(posedge CLOCK) begin
      if (RST) begin
         state_ff    <= S_IDLE;
         cnt_ff      <= 24'h0;
         widx_ff     <= {(LW+1){1'b0}};
         op_erase_ff <= 1'b0;
         row_ff      <= 10'h000;
         FL_ERASE    <= 1'b0;
         FL_PROG     <= 1'b0;
         FL_ADDR     <= 15'h0000;
         FL_WDATA    <= 14'h0000;
         CPU_STALL   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         FL_ERASE <= 1'b0;
         FL_PROG  <= 1'b0;
         if (state_ff == S_IDLE && go_ok) begin
            op_erase_ff <= erase_sel_ff;
            row_ff      <= {addr_hi_ff, addr_lo_ff[7:5]};
            widx_ff     <= {(LW+1){1'b0}};
         end
         if (state_ff == S_SETUP && nxt_state == S_ERASE) begin
            FL_ERASE <= 1'b1;
            FL_ADDR  <= {row_ff, 5'h00};
         end
         if (state_ff == S_PROG && widx_ff < NUM_LATCH[LW:0]) begin
            // Row stays fixed; only the low bits walk the latches
            FL_PROG  <= 1'b1;
            FL_ADDR  <= {row_ff, widx_ff[4:0]};
            FL_WDATA <= lat_rd;
            // Index runs one past the last latch, which ends the pulses
            widx_ff  <= widx_ff + {{LW{1'b0}}, 1'b1};
         end
         // Stall covers setup and the whole erase/program time
         CPU_STALL <= (nxt_state == S_SETUP) || (nxt_state == S_ERASE)
                      || (nxt_state == S_PROG);
      end
   end
   // ***********************************************************************
   // Register file
   // ***********************************************************************
   always @(posedge CLOCK) begin
      if (RST) begin
         addr_lo_ff    <= 8'h00;
         addr_hi_ff    <= 7'h00;
         data_lo_ff    <= 8'h00;
         data_hi_ff    <= 6'h00;
         prog_en_ff    <= 1'b0;
         erase_sel_ff  <= 1'b0;
         latch_only_ff <= 1'b0;
         cfg_sel_ff    <= 1'b0;
         prog_go_ff    <= 1'b0;
         fetch_go_ff   <= 1'b0;
         // Synchronous reset landing mid-operation marks it cut short
         wr_err_ff     <= busy_ff ? 1'b1 : wr_err_ff;
         busy_ff       <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != S_IDLE);
         if (wr_stb && PADDR == `OFS_ADDR_LOW) begin
            addr_lo_ff <= PWDATA[7:0];
         end
         if (wr_stb && PADDR == `OFS_ADDR_HIGH) begin
            addr_hi_ff <= PWDATA[6:0];
         end
         if (wr_stb && PADDR == `OFS_DATA_LOW) begin
            data_lo_ff <= PWDATA[7:0];
         end
         if (wr_stb && PADDR == `OFS_DATA_HIGH) begin
            data_hi_ff <= PWDATA[5:0];
         end
         if (ctl_wr) begin
            prog_en_ff    <= PWDATA[`CTL_PROG_EN];
            erase_sel_ff  <= PWDATA[`CTL_ERASE_SEL];
            latch_only_ff <= PWDATA[`CTL_LATCH_ONLY];
            cfg_sel_ff    <= PWDATA[`CTL_CFG_SEL];
            if (!PWDATA[`CTL_WR_ERR]) begin
               wr_err_ff <= 1'b0;
            end
         end
         // Go bits: set by software, cleared only by hardware
         if (go_ok) begin
            prog_go_ff <= 1'b1;
         end else if (nxt_state == S_IDLE) begin
            prog_go_ff <= 1'b0;
         end
         if (ctl_wr && PWDATA[`CTL_FETCH_GO]) begin
            fetch_go_ff <= 1'b1;
         end else if (fetch_go_ff) begin
            fetch_go_ff <= 1'b0;
         end
      end
   end
   // ***********************************************************************
   // APB answer: one wait state, ready in the second access cycle
   // ***********************************************************************
   always @(posedge CLOCK) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= access && !PREADY;
         PSLVERR <= 1'b0;
         if (setup || (access && PREADY)) begin
            PRDATA <= 32'h00000000;
         end else if (access && !PWRITE) begin
            case (PADDR)
               `OFS_ADDR_LOW:  PRDATA <= {24'h000000, addr_lo_ff};
               `OFS_ADDR_HIGH: PRDATA <= {25'h0000000, addr_hi_ff};
               `OFS_DATA_LOW:  PRDATA <= {24'h000000, data_lo_ff};
               `OFS_DATA_HIGH: PRDATA <= {26'h0000000, data_hi_ff};
               `OFS_CONTROL:   PRDATA <= {25'h0000000, cfg_sel_ff, latch_only_ff,
                                          erase_sel_ff, wr_err_ff, prog_en_ff,
                                          prog_go_ff, fetch_go_ff};
               `OFS_UNLOCK:    PRDATA <= 32'h00000000;
               default:        PRDATA <= 32'h00000000;
            endcase
            PSLVERR <= !(PADDR == `OFS_ADDR_LOW || PADDR == `OFS_ADDR_HIGH
                         || PADDR == `OFS_DATA_LOW || PADDR == `OFS_DATA_HIGH
                         || PADDR == `OFS_CONTROL || PADDR == `OFS_UNLOCK);
         end
      end
   end
endmodule
`default_nettype wire

//--- flash_seq_asserts.sv
// Checker for the flash sequencer: key gating, stall and flash strobes.
// Assumes one clock domain and the register map header.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_seq_asserts #(
   parameter NUM_LATCH = 32
) (
   // Clock and reset
   input wire logic        CLOCK,
   input wire logic        RST,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   // Sequencer
   input wire logic        CPU_STALL,
   input wire logic        FL_ERASE,
   input wire logic        FL_PROG,
   input wire logic [14:0] FL_ADDR
);
   // ****
   // Shadow state
   // ****
   logic [1:0] key_ff;
   logic       en_ff;
   logic       er_ff;
   logic [5:0] cnt_ff;
   logic [9:0] row_ff;
   wire        acc = PSEL && PENABLE && PREADY && PWRITE;
   wire        kw  = acc && PADDR == `OFS_UNLOCK;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         key_ff <= 2'h0;
         en_ff  <= 1'b0;
         er_ff  <= 1'b0;
         cnt_ff <= 6'h0;
      end else begin
         if (acc)
            key_ff <= (kw && PWDATA[7:0] == `KEY_FIRST) ? 2'h1 :
               (kw && PWDATA[7:0] == `KEY_SECOND && key_ff == 2'h1) ? 2'h2 : 2'h0;
         if (acc && PADDR == `OFS_CONTROL)
            en_ff <= PWDATA[`CTL_PROG_EN];
         // Erase seen in this stall; a program must never follow it
         er_ff  <= CPU_STALL && (er_ff || FL_ERASE);
         cnt_ff <= CPU_STALL ? cnt_ff + {5'h0, FL_PROG} : 6'h0;
      end
      if (FL_PROG)
         row_ff <= FL_ADDR[14:5];
   end
   // ****
   // Properties
   // ****
   property p_key_zero;
      PREADY && !PWRITE && PADDR == `OFS_UNLOCK |-> PRDATA == 32'h0;
   endproperty
   a_key_zero: assert property (p_key_zero) else $error("key read not zero");
   property p_setup;
      $rose(CPU_STALL) |-> (!FL_ERASE && !FL_PROG) [*2];
   endproperty
   a_setup: assert property (p_setup) else $error("no setup gap");
   property p_erase_row;
      FL_ERASE |-> FL_ADDR[4:0] == 5'h0;
   endproperty
   a_erase_row: assert property (p_erase_row) else $error("erase not row");
   property p_erase_stall;
      FL_ERASE |=> CPU_STALL [*8];
   endproperty
   a_erase_stall: assert property (p_erase_stall) else $error("erase not stalled");
   property p_prog_clean;
      FL_PROG |-> !er_ff && !FL_ERASE;
   endproperty
   a_prog_clean: assert property (p_prog_clean) else $error("erase in program");
   property p_prog_row;
      FL_PROG && cnt_ff != 6'h0 |-> FL_ADDR[14:5] == row_ff;
   endproperty
   a_prog_row: assert property (p_prog_row) else $error("row changed");
   property p_prog_max;
      FL_PROG |-> cnt_ff < NUM_LATCH;
   endproperty
   a_prog_max: assert property (p_prog_max) else $error("too many words");
   property p_start_key;
      $rose(CPU_STALL) |-> $past(key_ff) == 2'h2 || $past(key_ff, 2) == 2'h2;
   endproperty
   a_start_key: assert property (p_start_key) else $error("start unkeyed");
   property p_start_en;
      $rose(CPU_STALL) |-> $past(en_ff);
   endproperty
   a_start_en: assert property (p_start_en) else $error("start disabled");
   c_erase: cover property (FL_ERASE);
   c_full: cover property (FL_PROG && cnt_ff == 6'h1F);
   c_done: cover property ($fell(CPU_STALL));
endmodule
bind flash_seq flash_seq_asserts #(.NUM_LATCH(NUM_LATCH)) u_chk (.CLOCK(CLOCK), .RST(RST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .CPU_STALL(CPU_STALL), .FL_ERASE(FL_ERASE),
   .FL_PROG(FL_PROG), .FL_ADDR(FL_ADDR));
`default_nettype wire

//--- flash_row_erase_write_sequencer_bench.sv
// Bench for the flash sequencer: APB tasks, erase, lockout and programs.
// Assumes the register map header; flash times cut to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_row_erase_write_sequencer_bench;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rdv;
   logic        errv;
   wire  [31:0] prdata;
   wire         pready, pslverr, stall, fl_erase, fl_prog;
   wire  [14:0] fl_addr;
   wire  [13:0] fl_wdata;
   logic [14:0] eaddr;
   logic [9:0]  prow;
   logic [13:0] pdata [0:31];
   logic [13:0] want [0:31];
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          ecnt = 0;
   int          pcnt = 0;
   int          scnt = 0;
   int          s0;
   always #50 clock = ~clock;
   flash_seq #(.ERASE_CYC(20), .PROG_CYC(20)) DUT (.CLOCK(clock), .RST(rst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CPU_STALL(stall),
      .FL_ERASE(fl_erase), .FL_PROG(fl_prog), .FL_ADDR(fl_addr), .FL_WDATA(fl_wdata));
   // ****
   // Flash strobe monitor and timeout
   // ****
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (stall === 1'b1)
         scnt <= scnt + 1;
      if (fl_erase === 1'b1) begin
         ecnt  <= ecnt + 1;
         eaddr <= fl_addr;
      end
      if (fl_prog === 1'b1) begin
         pcnt <= pcnt + 1;
         prow <= fl_addr[14:5];
         pdata[fl_addr[4:0]] <= fl_wdata;
      end
      if (cyc == 5000) begin
         err_total = err_total + 1;
         conclude();
      end
   end
   // ****
   // Tasks
   // ****
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data is the value present at the ready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      // Only the bench timeout ends this wait
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rdv  = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   // Control first, then keys; brk 1 wrong key, brk 2 stray write
   task automatic go(input logic [31:0] ctl, input logic [1:0] brk);
      int n;
      n = 0;
      apb(1'b1, `OFS_CONTROL, ctl);
      apb(1'b1, `OFS_UNLOCK, 32'h55);
      if (brk == 2'h1)
         apb(1'b1, `OFS_UNLOCK, 32'h33);
      if (brk == 2'h2)
         apb(1'b1, `OFS_CONTROL, ctl);
      apb(1'b1, `OFS_UNLOCK, 32'hAA);
      apb(1'b1, `OFS_CONTROL, ctl | 32'h2);
      @(posedge clock);
      while (stall !== 1'b0 && n < 200) begin
         @(posedge clock);
         n++;
      end
      @(posedge clock);
      chk({31'h0, stall}, 32'h0);
   endtask
   task automatic ld(input logic [4:0] i, input logic [13:0] d);
      apb(1'b1, `OFS_ADDR_LOW, {24'h0, 3'h5, i});
      apb(1'b1, `OFS_DATA_LOW, {24'h0, d[7:0]});
      apb(1'b1, `OFS_DATA_HIGH, {26'h0, d[13:8]});
   endtask
   task automatic cmp_row;
      for (int i = 0; i < 32; i++)
         chk({18'h0, pdata[i]}, {18'h0, want[i]});
   endtask
   // ****
   // Tests
   // ****
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      apb(1'b0, `OFS_CONTROL, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b1, `OFS_UNLOCK, 32'h55);
      apb(1'b0, `OFS_UNLOCK, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({31'h0, errv}, 32'h1);
      $display("test registers done");
      apb(1'b1, `OFS_ADDR_HIGH, 32'h5A);
      apb(1'b1, `OFS_ADDR_LOW, 32'hB3);
      s0 = scnt;
      go(32'h14, 2'h0);
      chk(ecnt, 32'h1);
      chk({17'h0, eaddr}, 32'h5AA0);
      chk(scnt - s0 >= 22 && scnt - s0 <= 30, 32'h1);
      chk(pcnt, 32'h0);
      apb(1'b0, `OFS_CONTROL, 32'h0);
      chk(rdv, 32'h14);
      $display("test erase done");
      go(32'h14, 2'h1);
      go(32'h14, 2'h2);
      go(32'h10, 2'h0);
      chk(ecnt, 32'h1);
      $display("test lockout done");
      for (int i = 0; i < 32; i++)
         want[i] = 14'h3FFF;
      for (int i = 0; i < 3; i++) begin
         want[i] = 14'h2A50 + i[13:0];
         ld(i[4:0], want[i]);
         go(32'h24, 2'h0);
      end
      ld(5'h3, 14'h0555);
      go(32'h24, 2'h1);
      chk(pcnt, 32'h0);
      want[31] = 14'h15C3;
      ld(5'h1F, want[31]);
      go(32'h04, 2'h0);
      chk(pcnt, 32'h20);
      chk({22'h0, prow}, 32'h2D5);
      chk(ecnt, 32'h1);
      cmp_row();
      // A word left blank by the first program, so no erase is due
      for (int i = 0; i < 32; i++)
         want[i] = 14'h3FFF;
      want[4] = 14'h0001;
      ld(5'h4, want[4]);
      go(32'h04, 2'h0);
      chk(pcnt, 32'h40);
      cmp_row();
      $display("test program done");
      apb(1'b1, `OFS_CONTROL, 32'h14);
      apb(1'b1, `OFS_UNLOCK, 32'h55);
      apb(1'b1, `OFS_UNLOCK, 32'hAA);
      apb(1'b1, `OFS_CONTROL, 32'h16);
      // Reset lands while the erase is still in setup
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      apb(1'b0, `OFS_CONTROL, 32'h0);
      chk(rdv, 32'h8);
      chk(ecnt, 32'h1);
      $display("test reset done");
      conclude();
   end
endmodule
`default_nettype wire
